// File: core/pot_cfg.svh
// Constants for the dual potentiometer serial access block.
`ifndef POT_CFG_SVH
`define POT_CFG_SVH

// Frame layout: instruction byte first, data byte second.
`define FRAME_W        16
`define DATA_W         8
`define ADDR_W         5
`define FR_OP_HI       15
`define FR_OP_LO       13
`define FR_ADDR_HI     12
`define FR_ADDR_LO     8
`define FR_DATA_HI     7
`define FR_DATA_LO     0

// Register addresses.
`define ADDR_POT0      5'h00
`define ADDR_POT1      5'h01
`define ADDR_GP_FIRST  5'h02
`define ADDR_GP_LAST   5'h0E
`define ADDR_ACR       5'h10

// Control register bit positions.
`define ACR_VOL_BIT    7
`define ACR_SHDN_BIT   6
`define ACR_WIP_BIT    5
`define ACR_OD_BIT     1

// Reset values.
`define WIPER_RESET    8'h80
`define NV_RESET       8'h80
`define GP_RESET       8'h00
`define UNMAPPED_READ  8'h00
`define VOL_RESET      1'h0
`define SHDN_RESET     1'h1
`define OD_RESET       1'h0

// Timing: nonvolatile write time and the system clock rate.
`define CLK_FREQ_KHZ   100000
`define NV_WRITE_MS    20
`define NV_WRITE_CYC   (`NV_WRITE_MS * `CLK_FREQ_KHZ)

`endif

// File: core/pot_pkg.sv
// Types shared by the dual potentiometer serial access block.
package pot_pkg;

  // Operation codes carried in the upper three bits of an instruction byte.
  typedef enum logic [2:0] {
    OP_NOP    = 3'h0,
    OP_ACR_RD = 3'h1,
    OP_ACR_WR = 3'h3,
    OP_REG_RD = 3'h4,
    OP_REG_WR = 3'h6
  } op_t;

  // Command execution states, Gray coded along idle, execute, wait.
  typedef enum logic [1:0] {
    ST_IDLE    = 2'h0,
    ST_EXEC    = 2'h1,
    ST_NV_WAIT = 2'h3
  } sys_state_t;

endpackage

// File: core/pot_sync.sv
// Two flip-flop synchroniser for levels entering the system clock domain.
`timescale 1ns/1ps
module pot_sync #(
  parameter int         WIDTH     = 1,
  parameter logic [0:0] RESET_VAL = 1'h1
) (
  // Clock and reset.
  input  wire logic             clock_in,
  input  wire logic             rst_n_in,
  // Asynchronous level in, synchronised level out.
  input  wire logic [WIDTH-1:0] async_in,
  output logic      [WIDTH-1:0] sync_out
);

  logic [WIDTH-1:0] meta;

  // The first stage feeds only the second stage.
  always_ff @(posedge clock_in) begin
    if (!rst_n_in) begin
      meta     <= {WIDTH{RESET_VAL}};
      sync_out <= {WIDTH{RESET_VAL}};
    end else begin
      meta     <= async_in;
      sync_out <= meta;
    end
  end

endmodule

// File: core/pot_spi_daisy.sv
// Serial slave access logic of a dual digital potentiometer with daisy chaining.
`timescale 1ns/1ps
`include "pot_cfg.svh"
module pot_spi_daisy #(
  parameter int NV_WRITE_CYCLES = `NV_WRITE_CYC,
  parameter int COUNT_W         = 21
) (
  // System clock and reset.
  input  wire logic                clock_in,
  input  wire logic                rst_n_in,
  // Serial link from the host or the previous device.
  input  wire logic                sck_in,
  input  wire logic                cs_n_in,
  input  wire logic                sdi_in,
  // Serial output pin, split into data and enable.
  output logic                     sdo_out,
  output logic                     sdo_oe_out,
  output logic                     sdo_open_drain_out,
  // Potentiometer controls.
  output logic [`DATA_W-1:0]       wiper_0_out,
  output logic [`DATA_W-1:0]       wiper_1_out,
  output logic                     pot_active_out,
  output logic                     nv_busy_out
);

  ////////////////////////////////////////////////////////////////////////////////////////////
  // Elaboration checks.

  // The busy timer must hold the whole nonvolatile write time.
  generate
    if (NV_WRITE_CYCLES < 1 || NV_WRITE_CYCLES >= (2 ** COUNT_W)) begin : g_bad_count
      $error("NV_WRITE_CYCLES does not fit in COUNT_W bits");
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////////////////////////
  // Declarations.

  // Link domain.
  logic                    rx_bit;
  logic [`FRAME_W-1:0]     shreg;
  logic [`FRAME_W-1:0]     resp_hold;
  logic [`FRAME_W-1:0]     cur_word;
  logic                    fresh;
  logic [`FRAME_W-1:0]     next_frame;
  logic [`FRAME_W-1:0]     resp_cand;
  logic [`FRAME_W-1:0]     next_resp;
  logic [`FRAME_W-1:0]     cmd_word;
  logic [`ADDR_W-1:0]      rd_addr;
  logic [`DATA_W-1:0]      rd_data;
  pot_pkg::op_t            rd_op;

  // System domain.
  logic                    cs_n_sync;
  logic                    cs_n_prev;
  logic                    cs_rise;
  pot_pkg::sys_state_t     state;
  pot_pkg::sys_state_t     next_state;
  logic [COUNT_W-1:0]      nv_count;
  logic                    volatile_select_bit;
  logic                    shdn;
  logic                    write_pending_flag;
  logic                    od;
  logic [`DATA_W-1:0]      acr_value;
  logic [`DATA_W-1:0]      wiper    [0:1];
  logic [`DATA_W-1:0]      nv_store [0:1];
  logic [`DATA_W-1:0]      gp_mem   [`ADDR_GP_FIRST:`ADDR_GP_LAST];
  pot_pkg::op_t            ex_op;
  logic [`ADDR_W-1:0]      ex_addr;
  logic [`DATA_W-1:0]      ex_data;
  logic                    acr_we;
  logic [1:0]              wiper_we;
  logic [1:0]              nv_we;
  logic                    gp_we;
  logic                    nv_start;

  ////////////////////////////////////////////////////////////////////////////////////////////
  // Link domain: shifter, pass-through and response preparation.

  // Input is sampled on the rising serial clock edge, MSB first.
  always_ff @(posedge sck_in) begin
    rx_bit <= sdi_in;
  end

  // Until the first falling edge of a frame the answer held since the last chip select
  // rise stands in for the shifter, so it leaves first in the new frame.
  assign cur_word   = fresh ? resp_hold : shreg;
  assign next_frame = {cur_word[`FRAME_W-2:0], rx_bit};

  // Marks a frame in which no falling edge has come yet. Chip select presets it to a
  // constant, so no data word ever passes through an asynchronous load path.
  always_ff @(negedge sck_in or posedge cs_n_in) begin
    if (cs_n_in) begin
      fresh <= 1'h1;
    end else begin
      fresh <= 1'h0;
    end
  end

  // Output shifts on the falling edge. After sixteen clocks the shifter hands on
  // exactly what came in, so chained devices pass whole two-byte frames down the line.
  always_ff @(negedge sck_in) begin
    shreg <= next_frame;
  end

  // The prepared answer is held from the chip select rise until the next frame.
  always_ff @(posedge cs_n_in) begin
    resp_hold <= resp_cand;
  end

  assign sdo_out = cur_word[`FRAME_W-1];

  // Decode of the word that will sit in the shifter after the next falling edge.
  always_comb begin
    rd_op   = pot_pkg::op_t'(next_frame[`FR_OP_HI:`FR_OP_LO]);
    rd_addr = next_frame[`FR_ADDR_HI:`FR_ADDR_LO];
  end

  // Register read multiplexer. It reads system-domain registers directly; apart from the busy bit,
  // which clears whenever the write timer ends, they only change a few system clocks after a chip select rise,
  // while the serial clock is idle, so those values are stable whenever they are captured below.
  always_comb begin
    rd_data = `UNMAPPED_READ;
    if (rd_op == pot_pkg::OP_ACR_RD || rd_addr == `ADDR_ACR) begin
      rd_data = acr_value;
    end else if (rd_addr == `ADDR_POT0 || rd_addr == `ADDR_POT1) begin
      if (volatile_select_bit) begin
        rd_data = wiper[rd_addr[0]];
      end else begin
        rd_data = nv_store[rd_addr[0]];
      end
    end else if (rd_addr >= `ADDR_GP_FIRST && rd_addr <= `ADDR_GP_LAST && !volatile_select_bit) begin
      rd_data = gp_mem[rd_addr];
    end
  end

  // A read instruction is answered with its own instruction byte then the data; any
  // other frame is kept so that it keeps flowing down the chain in the next frame.
  always_comb begin
    next_resp = next_frame;
    if (rd_op == pot_pkg::OP_ACR_RD || rd_op == pot_pkg::OP_REG_RD) begin
      next_resp = {next_frame[`FR_OP_HI:`FR_ADDR_LO], rd_data};
    end
  end

  // The answer is prepared one falling edge ahead, so the load at chip select
  // rise copies a settled flip-flop rather than a changing decode.
  always_ff @(negedge sck_in) begin
    resp_cand <= next_resp;
  end

  // The last sixteen bits in the shifter at chip select rise are this device's command.
  always_ff @(posedge cs_n_in) begin
    cmd_word <= cur_word;
  end

  ////////////////////////////////////////////////////////////////////////////////////////////
  // System domain: chip select crossing and command execution.

  // Chip select enters through two flip-flops; cmd_word is stable from the rise on.
  pot_sync #(
    .WIDTH     (1),
    .RESET_VAL (1'h1)
  ) u_cs_sync (
    .clock_in (clock_in),
    .rst_n_in (rst_n_in),
    .async_in (cs_n_in),
    .sync_out (cs_n_sync)
  );

  // Edge detector on the synchronised chip select.
  always_ff @(posedge clock_in) begin
    if (!rst_n_in) begin
      cs_n_prev <= 1'h1;
    end else begin
      cs_n_prev <= cs_n_sync;
    end
  end

  assign cs_rise = cs_n_sync & ~cs_n_prev;

  // Fields of the captured command.
  always_comb begin
    ex_op   = pot_pkg::op_t'(cmd_word[`FR_OP_HI:`FR_OP_LO]);
    ex_addr = cmd_word[`FR_ADDR_HI:`FR_ADDR_LO];
    ex_data = cmd_word[`FR_DATA_HI:`FR_DATA_LO];
  end

  // Write strobes, raised only in the execute state. Reads need no action here;
  // they were answered in the link domain and never touch the wipers.
  always_comb begin
    acr_we   = 1'b0;
    wiper_we = 2'b00;
    nv_we    = 2'b00;
    gp_we    = 1'b0;
    if (state == pot_pkg::ST_EXEC) begin
      if (ex_op == pot_pkg::OP_ACR_WR) begin
        acr_we = 1'b1;
      end else if (ex_op == pot_pkg::OP_REG_WR) begin
        if (ex_addr == `ADDR_ACR) begin
          acr_we = 1'b1;
        end else if (ex_addr == `ADDR_POT0 || ex_addr == `ADDR_POT1) begin
          wiper_we[ex_addr[0]] = 1'b1;
          nv_we[ex_addr[0]]    = ~volatile_select_bit;
        end else if (ex_addr >= `ADDR_GP_FIRST && ex_addr <= `ADDR_GP_LAST) begin
          gp_we = ~volatile_select_bit;
        end
      end
    end
  end

  assign nv_start = gp_we | (|nv_we);

  // Command sequencer. Every device acts on the same chip select rise; while a
  // nonvolatile write is in progress new frames are not executed, which keeps the
  // stored values from being disturbed, but reads still answer.
  always_comb begin
    next_state = state;
    case (state)
      pot_pkg::ST_IDLE: begin
        if (cs_rise) begin
          next_state = pot_pkg::ST_EXEC;
        end
      end
      pot_pkg::ST_EXEC: begin
        if (nv_start) begin
          next_state = pot_pkg::ST_NV_WAIT;
        end else begin
          next_state = pot_pkg::ST_IDLE;
        end
      end
      pot_pkg::ST_NV_WAIT: begin
        if (nv_count == '0) begin
          next_state = pot_pkg::ST_IDLE;
        end
      end
      default: begin
        next_state = pot_pkg::ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge clock_in) begin
    if (!rst_n_in) begin
      state <= pot_pkg::ST_IDLE;
    end else begin
      state <= next_state;
    end
  end

  // Busy timer: loaded when the write starts, counts the nonvolatile write time down.
  always_ff @(posedge clock_in) begin
    if (!rst_n_in) begin
      nv_count <= '0;
    end else if (state == pot_pkg::ST_EXEC && nv_start) begin
      nv_count <= COUNT_W'(NV_WRITE_CYCLES - 1);
    end else if (nv_count != '0) begin
      nv_count <= nv_count - 1'b1;
    end
  end

  // Write-pending flag, a registered copy of the wait state.
  always_ff @(posedge clock_in) begin
    if (!rst_n_in) begin
      write_pending_flag <= 1'b0;
    end else begin
      write_pending_flag <= (next_state == pot_pkg::ST_NV_WAIT);
    end
  end

  // Control register bits that software writes.
  always_ff @(posedge clock_in) begin
    if (!rst_n_in) begin
      volatile_select_bit  <= `VOL_RESET;
      shdn <= `SHDN_RESET;
      od   <= `OD_RESET;
    end else if (acr_we) begin
      volatile_select_bit  <= ex_data[`ACR_VOL_BIT];
      shdn <= ex_data[`ACR_SHDN_BIT];
      od   <= ex_data[`ACR_OD_BIT];
    end
  end

  // Control register as read back; unused bits read as zero, busy is read-only.
  always_comb begin
    acr_value                = '0;
    acr_value[`ACR_VOL_BIT]  = volatile_select_bit;
    acr_value[`ACR_SHDN_BIT] = shdn;
    acr_value[`ACR_WIP_BIT]  = write_pending_flag;
    acr_value[`ACR_OD_BIT]   = od;
  end

  // Wiper registers: loaded by volatile writes and by power-up store writes alike.
  always_ff @(posedge clock_in) begin
    if (!rst_n_in) begin
      for (int i = 0; i < 2; i++) begin
        wiper[i] <= `WIPER_RESET;
      end
    end else begin
      for (int i = 0; i < 2; i++) begin
        if (wiper_we[i]) begin
          wiper[i] <= ex_data;
        end
      end
    end
  end

  // Power-up stores. Reset stands in for the factory content of the memory.
  always_ff @(posedge clock_in) begin
    if (!rst_n_in) begin
      for (int i = 0; i < 2; i++) begin
        nv_store[i] <= `NV_RESET;
      end
    end else begin
      for (int i = 0; i < 2; i++) begin
        if (nv_we[i]) begin
          nv_store[i] <= ex_data;
        end
      end
    end
  end

  // General purpose stores.
  always_ff @(posedge clock_in) begin
    if (!rst_n_in) begin
      for (int i = `ADDR_GP_FIRST; i <= `ADDR_GP_LAST; i++) begin
        gp_mem[i] <= `GP_RESET;
      end
    end else if (gp_we) begin
      gp_mem[ex_addr] <= ex_data;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////////////////
  // Outputs.

  // The pin is driven while chip select is low, as seen through the synchroniser.
  // This lags the pin by two to three system clocks; the host waits that long before
  // its first rising edge, a small price for keeping the enable free of glitches.
  always_ff @(posedge clock_in) begin
    if (!rst_n_in) begin
      sdo_oe_out         <= 1'b0;
      sdo_open_drain_out <= `OD_RESET;
    end else begin
      sdo_oe_out         <= ~cs_n_sync;
      sdo_open_drain_out <= od;
    end
  end

  // Potentiometer controls come straight from their registers.
  assign wiper_0_out    = wiper[0];
  assign wiper_1_out    = wiper[1];
  assign pot_active_out = shdn;
  assign nv_busy_out    = write_pending_flag;

endmodule

// File: dv/pot_spi_daisy_checker.sv
// Port-level assertions for the potentiometer serial access block.
`timescale 1ns/1ps
`include "pot_cfg.svh"
module pot_spi_daisy_checker #(
  parameter int NV_WRITE_CYCLES = `NV_WRITE_CYC
) (
  // System clock and reset.
  input wire logic               clock_in,
  input wire logic               rst_n_in,
  // Serial link.
  input wire logic               sck_in,
  input wire logic               cs_n_in,
  input wire logic               sdi_in,
  input wire logic               sdo_out,
  input wire logic               sdo_oe_out,
  input wire logic               sdo_open_drain_out,
  // Potentiometer controls.
  input wire logic [`DATA_W-1:0] wiper_0_out,
  input wire logic [`DATA_W-1:0] wiper_1_out,
  input wire logic               pot_active_out,
  input wire logic               nv_busy_out
);
  int busy_cnt;

  ////////////////////////////////////////////////////////////////////////////////
  // Counts busy cycles so the length of a nonvolatile write can be judged.
  always_ff @(posedge clock_in) begin
    if (!rst_n_in || !nv_busy_out) begin
      busy_cnt <= 0;
    end else begin
      busy_cnt <= busy_cnt + 1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // All checks live in the system clock domain; the link is seen only as sampled levels.
  default clocking cb @(posedge clock_in); endclocking
  default disable iff (!rst_n_in);

  sequence s_selected;
    !cs_n_in [*4];
  endsequence
  sequence s_deselected;
    cs_n_in [*8];
  endsequence

  property p_oe_on;      s_selected |-> sdo_oe_out; endproperty
  property p_oe_off;     cs_n_in [*4] |-> !sdo_oe_out; endproperty
  property p_wiper_hold; !cs_n_in [*6] |-> $stable(wiper_0_out) && $stable(wiper_1_out);
  endproperty
  property p_wiper_gate;
    ($changed(wiper_0_out) || $changed(wiper_1_out)) |-> $past(cs_n_in, 3);
  endproperty
  property p_ctrl_gate;
    ($changed(pot_active_out) || $changed(sdo_open_drain_out)) |-> $past(cs_n_in, 3);
  endproperty
  property p_busy_start; $rose(nv_busy_out) |-> $past(cs_n_in, 3); endproperty
  property p_busy_hold;  $rose(nv_busy_out) |=> nv_busy_out [*8]; endproperty
  property p_busy_len;
    $fell(nv_busy_out) |-> busy_cnt >= NV_WRITE_CYCLES && busy_cnt <= NV_WRITE_CYCLES + 1;
  endproperty
  property p_sdo_idle;   s_deselected |-> $stable(sdo_out); endproperty

  a_oe_on:      assert property (p_oe_on) else $error("output not driven while selected");
  a_oe_off:     assert property (p_oe_off) else $error("output driven while idle");
  a_wiper_hold: assert property (p_wiper_hold) else $error("wiper moved inside a frame");
  a_wiper_gate: assert property (p_wiper_gate) else $error("wiper moved without frame end");
  a_ctrl_gate:  assert property (p_ctrl_gate) else $error("control bit moved mid frame");
  a_busy_start: assert property (p_busy_start) else $error("busy rose mid frame");
  a_busy_hold:  assert property (p_busy_hold) else $error("busy pulse too short");
  a_busy_len:   assert property (p_busy_len) else $error("busy length wrong");
  a_sdo_idle:   assert property (p_sdo_idle) else $error("output bit moved between frames");
endmodule

bind pot_spi_daisy pot_spi_daisy_checker #(.NV_WRITE_CYCLES(NV_WRITE_CYCLES)) checker_i (
  .clock_in(clock_in), .rst_n_in(rst_n_in), .sck_in(sck_in), .cs_n_in(cs_n_in),
  .sdi_in(sdi_in), .sdo_out(sdo_out), .sdo_oe_out(sdo_oe_out),
  .sdo_open_drain_out(sdo_open_drain_out), .wiper_0_out(wiper_0_out),
  .wiper_1_out(wiper_1_out), .pot_active_out(pot_active_out), .nv_busy_out(nv_busy_out));

// File: dv/pot_host_model.sv
// Behavioural serial host that frames transfers for a chain of potentiometer blocks.
`timescale 1ns/1ps
module pot_host_model (
  // Shared link lines.
  output logic      sck_out,
  output logic      cs_n_out,
  output logic      sdi_out,
  // Data returned by the last device of the chain.
  input  wire logic sdo_in
);
  // The serial clock stands low outside frames.
  initial begin
    sck_out = 1'h0;
    cs_n_out = 1'h1;
    sdi_out = 1'h0;
  end

  ////////////////////////////////////////////////////////////////////////////////
  // One frame: select, shift the low nbits of tx MSB first, deselect and rest.
  task automatic xfer(input int nbits, input logic [63:0] tx, output logic [63:0] rx);
    rx = 64'h0;
    cs_n_out = 1'h0;
    #48;
    for (int i = nbits - 1; i >= 0; i--) begin
      sdi_out = tx[i];
      #6 sck_out = 1'h1;
      rx = {rx[62:0], sdo_in};
      #6 sck_out = 1'h0;
    end
    #6 cs_n_out = 1'h1;
    // A released data line must not look like the last bit, so it flips.
    sdi_out = ~sdi_out;
    #100;
  endtask
endmodule

// File: dv/test_dual_pot_spi_daisy_chain_access.sv
// Self-checking bench: two chained potentiometer blocks driven by a behavioural host.
`timescale 1ns/1ps
module test_dual_pot_spi_daisy_chain_access;
  localparam int NV_CYC = 300;
  logic        clock_in = 1'h0;
  logic        rst_n_in = 1'h0;
  logic        sck;
  logic        cs_n;
  logic        sdi;
  logic [1:0]  sdo;
  logic [1:0]  oe;
  logic [1:0]  od;
  logic [1:0]  act;
  logic [1:0]  busy;
  logic [15:0] w0;
  logic [15:0] w1;
  wire  [1:0]  pin;
  int          n_errors = 0;
  int          samples_checked = 0;

  ////////////////////////////////////////////////////////////////////////////////
  // Pins have a pull-up, so open drain and an idle pin both read high.
  assign pin = ~oe | sdo;
  always #5 clock_in = ~clock_in;

  // Device 0 takes the host data, device 1 takes the pin of device 0.
  pot_spi_daisy #(.NV_WRITE_CYCLES(NV_CYC)) pot_spi_daisy_i [1:0] (
    .clock_in(clock_in), .rst_n_in(rst_n_in), .sck_in(sck), .cs_n_in(cs_n),
    .sdi_in({pin[0], sdi}), .sdo_out(sdo), .sdo_oe_out(oe), .sdo_open_drain_out(od),
    .wiper_0_out(w0), .wiper_1_out(w1), .pot_active_out(act), .nv_busy_out(busy));
  pot_host_model pot_host_model_i (
    .sck_out(sck), .cs_n_out(cs_n), .sdi_out(sdi), .sdo_in(pin[1]));

  ////////////////////////////////////////////////////////////////////////////////
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      n_errors++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  // One chained frame; the word for the far device goes first.
  task automatic frame2(input logic [15:0] far_w, input logic [15:0] near_w);
    logic [63:0] r;
    pot_host_model_i.xfer(32, {32'h0, far_w, near_w}, r);
    @(negedge clock_in);
  endtask

  // Read in two frames: the requests, then no-operation words that bring the answers.
  task automatic read2(input logic [15:0] far_w, input logic [15:0] near_w,
                       input logic [31:0] exp);
    logic [63:0] r;
    frame2(far_w, near_w);
    pot_host_model_i.xfer(32, 64'h0, r);
    check(r[31:0], exp);
  endtask

  // Busy may last a full nonvolatile write, so the wait is bounded generously.
  task automatic wait_idle;
    for (int i = 0; i < 1000 && busy !== 2'h0; i++) @(negedge clock_in);
    check({30'h0, busy}, 32'h0);
  endtask

  task automatic conclude;
    $display("comparisons %0d mismatches %0d", samples_checked, n_errors);
    if (n_errors == 0 && samples_checked > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  task automatic t_reset;
    check({w0, w1}, 32'h80808080);
    check({24'h0, act, busy, oe, od}, 32'hC0);
    read2(16'h3000, 16'h3000, 32'h30403040);
    $display("test reset done");
  endtask

  task automatic t_control;
    frame2(16'h70C0, 16'h70C0);
    read2(16'h9000, 16'h9000, 32'h90C090C0);
    frame2(16'hD0C2, 16'hD0C0);
    check({24'h0, act, busy, oe, od}, 32'hC2);
    $display("test control done");
  endtask

  task automatic t_volatile;
    frame2(16'hC011, 16'hC122);
    check({w0[15:8], w1[7:0], 14'h0, busy}, 32'h11220000);
    read2(16'h8000, 16'h8100, 32'h80118122);
    $display("test volatile done");
  endtask

  task automatic t_nonvolatile;
    frame2(16'h7040, 16'h7040);
    frame2(16'h0000, 16'hC05A);
    check({w0[7:0], 22'h0, busy}, 32'h5A000001);
    frame2(16'h0000, 16'hC0AA);
    check({24'h0, w0[7:0]}, 32'h5A);
    read2(16'h3000, 16'h3000, 32'h30403060);
    wait_idle();
    frame2(16'h70C0, 16'h70C0);
    frame2(16'h0000, 16'hC033);
    frame2(16'h7040, 16'h7040);
    read2(16'h8000, 16'h8000, 32'h8080805A);
    check({24'h0, w0[7:0]}, 32'h33);
    $display("test nonvolatile done");
  endtask

  task automatic t_general;
    frame2(16'hCE3C, 16'hC2A5);
    wait_idle();
    read2(16'h8E00, 16'h8200, 32'h8E3C82A5);
    read2(16'h8F00, 16'h9100, 32'h8F009100);
    $display("test general done");
  endtask

  // Only no-operation words are sent, so nothing executes and data just flows.
  task automatic t_passthrough;
    logic [63:0] r;
    pot_host_model_i.xfer(64, 64'h1ABC012313570246, r);
    check(r[31:0], 32'h1ABC0123);
    $display("test passthrough done");
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  // Main sequence; an empty frame first gives each device a chip select rise with no serial clock edge.
  initial begin
    logic [63:0] r;
    repeat (10) @(posedge clock_in);
    rst_n_in <= 1'h1;
    repeat (4) @(posedge clock_in);
    pot_host_model_i.xfer(0, 64'h0, r);
    t_reset();
    t_control();
    t_volatile();
    t_nonvolatile();
    t_general();
    t_passthrough();
    conclude();
  end

  // The tests need about 20 us; this cuts a hang well beyond that.
  initial begin
    #500000;
    n_errors++;
    conclude();
  end
endmodule
